// >>> handler_cfg.svh
`ifndef HANDLER_CFG_SVH
`define HANDLER_CFG_SVH
// ****************************************************************
// register map (word addresses on the plain port)
// ****************************************************************
`define ADDR_W          4
`define REG_CTRL        4'h0
`define REG_SORT        4'h1
`define REG_STATUS      4'h2
`define REG_PORTC       4'h3
// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_DONE_BIT   0
`define CTRL_ABORT_BIT  1
// ****************************************************************
// status register fields
// ****************************************************************
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_START_BIT  2
`define STAT_LOCK_BIT   3
// ****************************************************************
// port c input bit positions (0 means active)
// ****************************************************************
`define PORTC_START_BIT 0
`define PORTC_LOCK_BIT  1
// ****************************************************************
// timing: data setup before end of test
// ****************************************************************
`define SETUP_NS        10000
`define CLK_NS          20
`define SETUP_CYC       ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CNT_W     10
// ****************************************************************
// result line positions
// ****************************************************************
`define SORT_W          16
`define NO_CONTACT_BIT  14
`define UNUSED_BIT      15
`define SORT_MASK       16'h7fff
`define SORT_RESET      16'h0000
`endif

// >>> handler_pkg.sv
package handler_pkg;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_MEAS  = 4'b0010,
        ST_SETUP = 4'b0100,
        ST_DONE  = 4'b1000
    } seq_e;
endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    genvar i;
    // ************************************************************
    // per-bit double flop
    // ************************************************************
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta_r[i] <= 1'b1;
                    q[i]      <= 1'b1;
                end else begin
                    meta_r[i] <= d[i];
                    q[i]      <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> component_handler_io_port.sv
`include "handler_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module component_handler_io_port (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // register port
    input  wire logic [`ADDR_W-1:0]   addr,
    input  wire logic [31:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [31:0]          rdata,
    // isolator pins (low = current flowing)
    input  wire logic                 start_iso_n,
    input  wire logic                 aux_fire_n,
    input  wire logic                 interlock_iso_n,
    // open collector outputs: low enable pulls pin low
    output logic      [`SORT_W-1:0]   sort_result_oe_n,
    output logic                      busy_oe_n,
    output logic                      test_done_oe_n,
    // status to measurement logic
    output logic                      start_req,
    output logic                      interlock_n
);
    localparam int SC = `SETUP_CYC;
    handler_pkg::seq_e state_r, state_nxt;
    logic [`SORT_W-1:0]     sort_r;      // latched, driven to pins
    logic [`SORT_W-1:0]     sort_pend_r; // staged by software
    logic [`SETUP_CNT_W-1:0] cnt_r;
    logic                   start_q, start_d_r, lock_q;
    logic                   merged_n;
    logic                   fall;
    logic                   done_wr, abort_wr, sort_wr;
    logic                   busy_w, done_w;
    logic [1:0]             sync_q;

    // ************************************************************
    // input capture
    // ************************************************************
    // wired-or merge
    assign merged_n = start_iso_n & aux_fire_n;
    pin_sync #(.W(2)) u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .d       ({interlock_iso_n, merged_n}),
        .rst_val (2'h3),
        .q       (sync_q)
    );
    assign start_q = sync_q[`PORTC_START_BIT];
    assign lock_q  = sync_q[`PORTC_LOCK_BIT];
    assign interlock_n = lock_q;

    // previous merged level for edge detect
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_d_r <= 1'b1;
        end else begin
            start_d_r <= start_q;
        end
    end
    assign fall = start_d_r & ~start_q;

    // ************************************************************
    // write decode
    // ************************************************************
    assign sort_wr  = wr && (addr == `REG_SORT);
    assign done_wr  = wr && (addr == `REG_CTRL) && wdata[`CTRL_DONE_BIT];
    assign abort_wr = wr && (addr == `REG_CTRL) && wdata[`CTRL_ABORT_BIT];

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            handler_pkg::ST_IDLE, handler_pkg::ST_DONE: begin
                if (fall) begin
                    state_nxt = handler_pkg::ST_MEAS;
                end
            end
            handler_pkg::ST_MEAS: begin
                if (done_wr) begin
                    state_nxt = handler_pkg::ST_SETUP;
                end else if (abort_wr) begin
                    state_nxt = handler_pkg::ST_IDLE;
                end
            end
            handler_pkg::ST_SETUP: begin
                if (cnt_r == `SETUP_CNT_W'(SC - 1)) begin
                    state_nxt = handler_pkg::ST_DONE;
                end
            end
            default: state_nxt = handler_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= handler_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // setup counter runs only in the setup state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (state_r == handler_pkg::ST_SETUP) begin
            cnt_r <= cnt_r + `SETUP_CNT_W'(1);
        end else begin
            cnt_r <= '0;
        end
    end

    // ************************************************************
    // result registers
    // ************************************************************
    // line 16 never asserted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sort_pend_r <= `SORT_RESET;
        end else if (sort_wr) begin
            sort_pend_r <= wdata[`SORT_W-1:0] & `SORT_MASK;
        end
    end
    // pins change only on the done write, a setup time ahead of end of test
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sort_r <= `SORT_RESET;
        end else if (state_r == handler_pkg::ST_MEAS && done_wr) begin
            sort_r <= sort_pend_r;
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    // busy low during measurement and setup
    assign busy_w = (state_r == handler_pkg::ST_MEAS) ||
                    (state_r == handler_pkg::ST_SETUP);
    // done released at start; swaps with busy
    assign done_w = (state_r == handler_pkg::ST_DONE);
    // active low open collector; 1 asserts
    // lines 1-10 bins; lines 11-14 limits
    assign sort_result_oe_n = ~sort_r;
    assign busy_oe_n        = ~busy_w;
    assign test_done_oe_n   = ~done_w;
    assign start_req        = fall && !busy_w;

    // ************************************************************
    // read port
    // ************************************************************
    // port c reads 0 for an active input; status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                `REG_SORT:   rdata <= {16'h0, sort_r};
                `REG_STATUS: rdata <= {28'h0, lock_q, start_q,
                                       done_w, busy_w};
                `REG_PORTC:  rdata <= {30'h0, lock_q, start_q};
                default:     rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // busy held
    property p_busy_hold;
        @(posedge clk) disable iff (!resetn)
        (state_r == handler_pkg::ST_MEAS && !done_wr && !abort_wr)
            |=> !busy_oe_n;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
    property p_done_off;
        @(posedge clk) disable iff (!resetn)
        busy_w |-> test_done_oe_n;
    endproperty
    a_done_off: assert property (p_done_off) else $error("done in busy");
    property p_hold;
        @(posedge clk) disable iff (!resetn)
        (state_r != handler_pkg::ST_MEAS) |=> $stable(sort_r);
    endproperty
    a_hold: assert property (p_hold) else $error("results moved");
    sequence s_end;
        $rose(done_w);
    endsequence
    property p_swap;
        @(posedge clk) disable iff (!resetn)
        s_end |-> $past(busy_w) && !busy_w;
    endproperty
    a_swap: assert property (p_swap) else $error("not simultaneous");
    property p_setup;
        @(posedge clk) disable iff (!resetn)
        s_end |-> $past(state_r == handler_pkg::ST_SETUP);
    endproperty
    a_setup: assert property (p_setup) else $error("no setup");
    property p_spare;
        @(posedge clk) disable iff (!resetn)
        sort_result_oe_n[`UNUSED_BIT];
    endproperty
    a_spare: assert property (p_spare) else $error("line 16 on");
    property p_lock;
        @(posedge clk) disable iff (!resetn)
        interlock_n == sync_q[`PORTC_LOCK_BIT];
    endproperty
    a_lock: assert property (p_lock) else $error("interlock");
    property p_ignore;
        @(posedge clk) disable iff (!resetn)
        busy_w |-> !start_req;
    endproperty
    a_ignore: assert property (p_ignore) else $error("start in busy");
    property p_start;
        @(posedge clk) disable iff (!resetn)
        (fall && state_r == handler_pkg::ST_IDLE) |=> busy_w;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_merge;
        @(posedge clk) disable iff (!resetn)
        (!start_iso_n || !aux_fire_n) |-> !merged_n;
    endproperty
    a_merge: assert property (p_merge) else $error("merge");
    property p_abort;
        @(posedge clk) disable iff (!resetn)
        (state_r == handler_pkg::ST_MEAS && abort_wr && !done_wr)
            |=> busy_oe_n && test_done_oe_n;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_restart;
        @(posedge clk) disable iff (!resetn)
        (state_r == handler_pkg::ST_DONE && fall)
            |=> test_done_oe_n && !busy_oe_n;
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_eot_hold;
        @(posedge clk) disable iff (!resetn)
        (state_r == handler_pkg::ST_DONE && !fall) |=> !test_done_oe_n;
    endproperty
    a_eot_hold: assert property (p_eot_hold) else $error("eot lost");
    sequence s_latch;
        state_r == handler_pkg::ST_MEAS && done_wr;
    endsequence
    property p_setup_busy;
        @(posedge clk) disable iff (!resetn)
        s_latch |=> (!busy_oe_n) [*8];
    endproperty
    a_setup_busy: assert property (p_setup_busy) else $error("short");
    property p_done_rd;
        @(posedge clk) disable iff (!resetn)
        (rd && addr == `REG_STATUS && done_w) |=> rdata[`STAT_DONE_BIT];
    endproperty
    a_done_rd: assert property (p_done_rd) else $error("done read");
    property p_spare_pend;
        @(posedge clk) disable iff (!resetn)
        !sort_pend_r[`UNUSED_BIT];
    endproperty
    a_spare_pend: assert property (p_spare_pend) else $error("spare");
    property p_portc;
        @(posedge clk) disable iff (!resetn)
        (rd && addr == `REG_PORTC) |=> rdata[1:0] == $past(sync_q);
    endproperty
    a_portc: assert property (p_portc) else $error("port c");
    // read data only after a read
    property p_rd_idle;
        @(posedge clk) disable iff (!resetn)
        !rd |=> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray data");
    property p_req_once;
        @(posedge clk) disable iff (!resetn)
        start_req |=> !start_req;
    endproperty
    a_req_once: assert property (p_req_once) else $error("double req");
endmodule
`default_nettype wire

// >>> handler_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// handler side: pulses one trigger pin, then lets it go
// ****************************************************************
module handler_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       use_aux,
    input  wire logic [3:0] hold,
    output logic            start_iso_n,
    output logic            aux_fire_n
);
    logic [3:0] left_r = 4'h0;
    logic       aux_r  = 1'b0;

    always @(posedge clk) begin
        if (go) begin
            left_r <= hold;
            aux_r  <= use_aux;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end

    // a released pin sits at its pulled-up idle level
    assign start_iso_n = !(left_r != 4'h0 && !aux_r);
    assign aux_fire_n  = !(left_r != 4'h0 && aux_r);
endmodule
`default_nettype wire

// >>> component_handler_io_port_tb.sv
`include "handler_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module component_handler_io_port_tb;
    logic        clk, resetn, wr, rd, go, use_aux, lock_n;
    logic [3:0]  addr, hold;
    logic [31:0] wdata, rdata, v;
    logic [15:0] sort_oe_n;
    logic        busy_oe_n, done_oe_n, start_req, interlock_n;
    logic        start_iso_n, aux_fire_n;
    int          err_count, total_checks, req_cnt, cyc;

    component_handler_io_port i_dut (
        .clk              (clk),
        .resetn           (resetn),
        .addr             (addr),
        .wdata            (wdata),
        .wr               (wr),
        .rd               (rd),
        .rdata            (rdata),
        .start_iso_n      (start_iso_n),
        .aux_fire_n       (aux_fire_n),
        .interlock_iso_n  (lock_n),
        .sort_result_oe_n (sort_oe_n),
        .busy_oe_n        (busy_oe_n),
        .test_done_oe_n   (done_oe_n),
        .start_req        (start_req),
        .interlock_n      (interlock_n)
    );

    handler_model i_handler (
        .clk         (clk),
        .go          (go),
        .use_aux     (use_aux),
        .hold        (hold),
        .start_iso_n (start_iso_n),
        .aux_fire_n  (aux_fire_n)
    );

    // ****************************************************************
    // clock, request counter and hang guard
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start_req === 1'b1) req_cnt <= req_cnt + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    // fire one trigger pin, wait for busy within a few cycles
    task automatic fire(input logic aux, input logic [3:0] len);
        int n;
        @(posedge clk);
        go      <= 1'b1;
        use_aux <= aux;
        hold    <= len;
        @(posedge clk);
        go      <= 1'b0;
        n = 0;
        while (busy_oe_n !== 1'b0 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    // one whole test: start, stage results, finish
    task automatic run_test(input logic aux, input logic [3:0] len,
                            input logic [31:0] s);
        int          n;
        logic [15:0] prev, pins_exp;
        n    = req_cnt;
        prev = sort_oe_n;
        fire(aux, len);
        check("busy", busy_oe_n, 1'b0);
        check("done", done_oe_n, 1'b1);
        check("reqs", req_cnt, n + 1);
        fire(!aux, len);
        repeat (6) @(posedge clk);
        check("ignored", req_cnt, n + 1);
        reg_rd(`REG_STATUS);
        check("stat", v[1:0], 2'b01);
        reg_wr(`REG_SORT, s);
        check("held", sort_oe_n, prev);
        reg_wr(`REG_CTRL, 32'h0000_0001);
        pins_exp = ~(s[15:0] & 16'h7fff);
        @(posedge clk);
        #1 check("pins", sort_oe_n, pins_exp);
        check("busy", busy_oe_n, 1'b0);
        n = 1;
        while (busy_oe_n !== 1'b1 && n < 600) begin
            check("pair", done_oe_n, 1'b1);
            @(posedge clk);
            #1 n++;
        end
        check("setup", (n >= 499 && n <= 501), 1'b1);
        check("eot", done_oe_n, 1'b0);
        reg_rd(`REG_SORT);
        check("sort", v, s & 32'h7fff);
        reg_rd(`REG_STATUS);
        check("stat", v[1:0], 2'b10);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {resetn, wr, rd, go, use_aux} = 5'b00000;
        {lock_n, addr, hold, wdata} = {1'b1, 4'h0, 4'h4, 32'h0};
        err_count = 0;
        total_checks = 0;
        req_cnt = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1 check("oe", {sort_oe_n, busy_oe_n, done_oe_n}, 18'h3ffff);
        check("lock", interlock_n, 1'b1);
        reg_rd(4'hf);
        check("unmapped", v, 32'h0);
        run_test(1'b0, 4'h4, 32'h0000_a5c3);
        run_test(1'b1, 4'hc, 32'h0000_ffff);
        // trigger seen on the input port while held low
        @(posedge clk);
        go   <= 1'b1;
        hold <= 4'hc;
        @(posedge clk);
        go   <= 1'b0;
        repeat (3) @(posedge clk);
        reg_rd(`REG_PORTC);
        check("portc", v[0], 1'b0);
        // abort drops busy and done, keeps results
        reg_wr(`REG_CTRL, 32'h0000_0002);
        repeat (2) @(posedge clk);
        #1 check("abort", {busy_oe_n, done_oe_n}, 2'b11);
        check("kept", sort_oe_n, 16'h8000);
        @(posedge clk);
        lock_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check("lock", interlock_n, 1'b0);
        reg_rd(`REG_PORTC);
        check("portc", v[1], 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
